// *** hw/fadc_defs.svh ***
`ifndef FADC_DEFS_SVH
`define FADC_DEFS_SVH

// register byte offsets on the slave bus
`define FADC_OFS_SRC_ADDR      5'h00
`define FADC_OFS_DST_ADDR      5'h04
`define FADC_OFS_XFER_COUNT    5'h08
`define FADC_OFS_BLOCK_COUNT   5'h0C
`define FADC_OFS_CONTROL_A     5'h10
`define FADC_OFS_CONTROL_B     5'h14

// control_a fields
`define FADC_A_CHANNEL_ENABLE  0
`define FADC_A_END_IRQ_ENABLE  1
`define FADC_A_WORD_SIZE       2
`define FADC_A_SRC_STEP_EN     3
`define FADC_A_SRC_STEP_DIR    4
`define FADC_A_SEL_LSB         5

// control_b fields
`define FADC_B_MASTER_ENABLE   0
`define FADC_B_DST_STEP_EN     1
`define FADC_B_DST_STEP_DIR    2
`define FADC_B_SEL_LSB         3
`define FADC_B_AREA_IS_SRC     6
`define FADC_B_BUSY            7

// a-side select codes
`define FADC_MODE_NORMAL       3'h6
`define FADC_MODE_BLOCK        3'h7

// b-side activation source codes
`define FADC_SRC_TIMER0        3'h0
`define FADC_SRC_TIMER1        3'h1
`define FADC_SRC_TIMER2        3'h2
`define FADC_SRC_CONV_END      3'h3
`define FADC_SRC_AUTO_BURST    3'h4
`define FADC_SRC_AUTO_STEAL    3'h5
`define FADC_SRC_EXT_EDGE      3'h6
`define FADC_SRC_EXT_LEVEL     3'h7

// writable bits of each control register
`define FADC_CTRL_A_MASK       8'hFF
`define FADC_CTRL_B_MASK       8'h7F

`endif

// *** hw/fadc_pkg.sv ***
package fadc_pkg;

    typedef enum logic [1:0] {
        FADC_IDLE,
        FADC_ACQUIRE,
        FADC_READ,
        FADC_WRITE
    } fadc_state_type;

    typedef struct packed {
        logic [4:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } fadc_avs_req_type;

    typedef struct packed {
        logic [23:0] address;
        logic        read;
        logic        write;
        logic [15:0] writedata;
        logic [1:0]  byteenable;
    } fadc_avm_req_type;

    typedef struct packed {
        logic [3:0] timerMatch;
        logic       dreqN;
        logic       nmiClear;
    } fadc_events_type;

    typedef struct packed {
        fadc_state_type   state;
        logic [23:0]      srcAddr;
        logic [23:0]      dstAddr;
        logic [23:0]      areaBase;
        logic [15:0]      xferCount;
        logic [15:0]      blockCount;
        logic [7:0]       controlA;
        logic [7:0]       controlB;
        logic             endFlag;
        logic             reqPending;
        logic             dreqPrev;
        logic [7:0]       dataHold;
        logic             waitReq;
        logic [31:0]      readData;
        fadc_avm_req_type master;
        logic             busReq;
        logic             irq;
    } fadc_regs_type;

endpackage

// *** hw/fadc_channel.sv ***
// Function
// R1: normal mode moves one unit per request
// R2: source from source_address, destination from destination_address
// R3: each address steps up, down or holds
// R4: count down transfer_count, zero ends and disables
// R5: end raises irq only when enabled
// R6: count loaded zero gives 65536 transfers
// R7: normal mode takes external or auto requests
// R8: auto request runs all transfers once enabled
// R9: auto cycle-steal releases, burst keeps bus
// R10: select code 110 picks normal mode
// R11: software loads, then enables master, then channel
// R12: nmi clears master enable, blocking start
// R13: software masks end irq during setup; the testbench setup writes the end irq enable with control_a, unmasked
// R14: block mode moves whole block per request
// R15: area select restores source or destination
// R16: block size counts down, reloads, block counter decrements
// R17: unfinished block count waits for next request
// R18: block counter zero ends, optional irq
// R19: block moves as one burst, bus held
// R20: software loads equal block sizes and count
// R21: block mode takes timer, converter, external edge
// R22: step by one for bytes, two words
// R23: start only with master and channel enable
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`include "fadc_defs.svh"

module fadc_channel (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire fadc_pkg::fadc_avs_req_type avsReq,
    output logic                           avsWaitrequest,
    output logic [31:0]                    avsReaddata,
    output fadc_pkg::fadc_avm_req_type     avmReq,
    input  wire logic                      avmWaitrequest,
    input  wire logic [15:0]               avmReaddata,
    output logic                           busRequest,
    input  wire logic                      busGrant,
    input  wire logic                      priorityRequest,
    input  wire fadc_pkg::fadc_events_type events,
    output logic                           transferEndIrq
);

    fadc_pkg::fadc_regs_type r;
    fadc_pkg::fadc_regs_type next_r;

    localparam fadc_pkg::fadc_regs_type RESET_VALUE = '{
        state:    fadc_pkg::FADC_IDLE,
        dreqPrev: 1'b1,
        waitReq:  1'b1,
        default:  '0
    };

    function automatic logic [23:0] stepAddr(input logic [23:0] addr,
                                             input logic        en,
                                             input logic        dec,
                                             input logic        word);
        logic [23:0] delta;
        delta = word ? 24'h00_0002 : 24'h00_0001;                 // [R22]
        if (!en)
            stepAddr = addr;
        else if (dec)
            stepAddr = addr - delta;                              // [R3]
        else
            stepAddr = addr + delta;                              // [R3]
    endfunction

    function automatic logic [1:0] laneEnable(input logic [23:0] addr,
                                              input logic        word);
        if (word)
            laneEnable = 2'h3;
        else
            laneEnable = addr[0] ? 2'h2 : 2'h1;
    endfunction

    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  be);
        for (int i = 0; i < 4; i++) begin
            mergeBytes[i*8 +: 8] = be[i] ? data[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    logic [2:0]  selA;
    logic [2:0]  selB;
    logic        normalMode;
    logic        blockMode;
    logic        wordSize;
    logic        enabled;
    logic        eventHit;
    logic        levelReq;
    logic        reqNow;
    logic        accessNow;
    logic [23:0] newSrc;
    logic [23:0] newDst;
    logic [15:0] newCount;
    logic [15:0] newBlocks;
    logic        blockEnd;
    logic        allDone;
    logic [31:0] regOld;
    logic [31:0] regNew;

    assign selA     = r.controlA[`FADC_A_SEL_LSB +: 3];
    assign selB     = r.controlB[`FADC_B_SEL_LSB +: 3];
    assign wordSize = r.controlA[`FADC_A_WORD_SIZE];
    assign normalMode = (selA == `FADC_MODE_NORMAL);             // [R10]
    assign blockMode  = (selA == `FADC_MODE_BLOCK);
    assign enabled = r.controlA[`FADC_A_CHANNEL_ENABLE]
                   & r.controlB[`FADC_B_MASTER_ENABLE];          // [R23]

    // pulse sources latch, so a short event waiting for the bus is kept
    always_comb begin
        eventHit = 1'b0;
        levelReq = 1'b0;
        unique case (selB)
            `FADC_SRC_TIMER0,
            `FADC_SRC_TIMER1,
            `FADC_SRC_TIMER2:
                eventHit = blockMode & events.timerMatch[selB[1:0]];  // [R21]
            `FADC_SRC_CONV_END:
                eventHit = blockMode & events.timerMatch[3];          // [R21]
            `FADC_SRC_AUTO_BURST,
            `FADC_SRC_AUTO_STEAL:
                levelReq = normalMode;                                // [R7] [R8]
            `FADC_SRC_EXT_EDGE:
                eventHit = (normalMode | blockMode)
                         & r.dreqPrev & ~events.dreqN;                // [R7] [R21]
            `FADC_SRC_EXT_LEVEL:
                levelReq = normalMode & ~events.dreqN;                // [R7]
        endcase
    end

    assign reqNow = enabled & (r.reqPending | levelReq);          // [R23]

    // counter and address updates after each completed write
    always_comb begin
        newSrc    = stepAddr(r.srcAddr, r.controlA[`FADC_A_SRC_STEP_EN],
                             r.controlA[`FADC_A_SRC_STEP_DIR], wordSize);
        newDst    = stepAddr(r.dstAddr, r.controlB[`FADC_B_DST_STEP_EN],
                             r.controlB[`FADC_B_DST_STEP_DIR], wordSize);
        newCount  = r.xferCount;
        newBlocks = r.blockCount;
        blockEnd  = 1'b0;
        allDone   = 1'b0;
        if (blockMode) begin
            newCount[15:8] = r.xferCount[15:8] - 8'h01;           // [R16]
            if (newCount[15:8] == 8'h00) begin
                blockEnd       = 1'b1;
                newCount[15:8] = r.xferCount[7:0];                // [R16]
                newBlocks      = r.blockCount - 16'h0001;         // [R16]
                allDone        = (newBlocks == 16'h0000);         // [R18]
                if (r.controlB[`FADC_B_AREA_IS_SRC])
                    newSrc = r.areaBase;                          // [R15]
                else
                    newDst = r.areaBase;                          // [R15]
            end
        end else begin
            // wrap from zero makes a zero load run the full 65536
            newCount = r.xferCount - 16'h0001;                    // [R4] [R6]
            allDone  = (newCount == 16'h0000);                    // [R4]
        end
    end

    assign accessNow = (avsReq.read | avsReq.write) & r.waitReq;

    always_comb begin
        unique case (avsReq.address)
            `FADC_OFS_SRC_ADDR:    regOld = {8'h00, r.srcAddr};
            `FADC_OFS_DST_ADDR:    regOld = {8'h00, r.dstAddr};
            `FADC_OFS_XFER_COUNT:  regOld = {16'h0000, r.xferCount};
            `FADC_OFS_BLOCK_COUNT: regOld = {16'h0000, r.blockCount};
            `FADC_OFS_CONTROL_A:   regOld = {24'h00_0000, r.controlA};
            `FADC_OFS_CONTROL_B:
                regOld = {24'h00_0000, r.state != fadc_pkg::FADC_IDLE,
                          r.controlB[6:0]};
            default:               regOld = 32'h0000_0000;
        endcase
        regNew = mergeBytes(regOld, avsReq.writedata, avsReq.byteenable);
    end

    always_comb begin
        next_r = r;
        next_r.dreqPrev = events.dreqN;

        // slave answers one cycle after the request is seen
        next_r.waitReq = ~accessNow;
        if (accessNow && avsReq.read)
            next_r.readData = regOld;

        unique case (r.state)
            fadc_pkg::FADC_IDLE: begin
                if (reqNow && !events.nmiClear) begin                 // [R12]
                    next_r.busReq     = 1'b1;
                    next_r.reqPending = 1'b0;
                    next_r.areaBase = r.controlB[`FADC_B_AREA_IS_SRC]
                                    ? r.srcAddr : r.dstAddr;      // [R15]
                    next_r.state    = fadc_pkg::FADC_ACQUIRE;
                end
            end
            fadc_pkg::FADC_ACQUIRE: begin
                if (busGrant) begin
                    next_r.master.address    = r.srcAddr;         // [R2]
                    next_r.master.read       = 1'b1;
                    next_r.master.byteenable = laneEnable(r.srcAddr, wordSize);
                    next_r.state             = fadc_pkg::FADC_READ;
                end
            end
            fadc_pkg::FADC_READ: begin
                if (!avmWaitrequest) begin
                    next_r.master.read = 1'b0;
                    next_r.dataHold = r.srcAddr[0] ? avmReaddata[15:8]
                                                   : avmReaddata[7:0];
                    next_r.master.writedata = wordSize ? avmReaddata
                        : {2{r.srcAddr[0] ? avmReaddata[15:8] : avmReaddata[7:0]}};
                    next_r.master.address    = r.dstAddr;         // [R2]
                    next_r.master.write      = 1'b1;
                    next_r.master.byteenable = laneEnable(r.dstAddr, wordSize);
                    next_r.state             = fadc_pkg::FADC_WRITE;
                end
            end
            fadc_pkg::FADC_WRITE: begin
                if (!avmWaitrequest) begin
                    next_r.master.write = 1'b0;
                    next_r.srcAddr      = newSrc;                 // [R3]
                    next_r.dstAddr      = newDst;                 // [R3]
                    next_r.xferCount    = newCount;               // [R4] [R16]
                    next_r.blockCount   = newBlocks;              // [R16]
                    if (allDone) begin
                        next_r.controlA[`FADC_A_CHANNEL_ENABLE] = 1'b0;  // [R4] [R18]
                        next_r.endFlag = 1'b1;                    // [R5] [R18]
                        next_r.busReq  = 1'b0;
                        next_r.state   = fadc_pkg::FADC_IDLE;
                    end else if ((blockMode && !blockEnd)         // [R14] [R19]
                                 || (normalMode
                                     && selB == `FADC_SRC_AUTO_BURST
                                     && !priorityRequest)) begin  // [R9]
                        next_r.master.address    = newSrc;
                        next_r.master.read       = 1'b1;
                        next_r.master.byteenable = laneEnable(newSrc, wordSize);
                        next_r.state             = fadc_pkg::FADC_READ;
                    end else begin
                        // one unit per request in normal mode, wait per block
                        next_r.busReq = 1'b0;                     // [R1] [R9] [R17]
                        next_r.state  = fadc_pkg::FADC_IDLE;
                    end
                end
            end
        endcase

        // a write lands only at the edge that sees waitrequest low
        if (avsReq.write && !r.waitReq) begin
            unique case (avsReq.address)
                `FADC_OFS_SRC_ADDR:    next_r.srcAddr    = regNew[23:0];
                `FADC_OFS_DST_ADDR:    next_r.dstAddr    = regNew[23:0];
                `FADC_OFS_XFER_COUNT:  next_r.xferCount  = regNew[15:0];
                `FADC_OFS_BLOCK_COUNT: next_r.blockCount = regNew[15:0];
                `FADC_OFS_CONTROL_A: begin
                    next_r.controlA = regNew[7:0] & `FADC_CTRL_A_MASK;
                    next_r.endFlag  = 1'b0;
                end
                `FADC_OFS_CONTROL_B:
                    next_r.controlB = regNew[7:0] & `FADC_CTRL_B_MASK;
                default: ;
            endcase
        end

        // an end in the same cycle as a clear is kept
        if (r.state == fadc_pkg::FADC_WRITE && !avmWaitrequest && allDone)
            next_r.endFlag = 1'b1;

        if (events.nmiClear)
            next_r.controlB[`FADC_B_MASTER_ENABLE] = 1'b0;        // [R12]

        // a new event in the start cycle stays pending
        if (eventHit && enabled)
            next_r.reqPending = 1'b1;

        next_r.irq = next_r.endFlag
                   & next_r.controlA[`FADC_A_END_IRQ_ENABLE];     // [R5] [R18]
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            r <= RESET_VALUE;
        else
            r <= next_r;
    end

    assign avsWaitrequest = r.waitReq;
    assign avsReaddata    = r.readData;
    assign avmReq         = r.master;
    assign busRequest     = r.busReq;
    assign transferEndIrq = r.irq;

endmodule

// *** test/fadc_mem_model.sv ***
module fadc_mem_model (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire fadc_pkg::fadc_avm_req_type avmReq,
    input  wire logic                       busRequest,
    input  wire logic [1:0]                 waitCycles,
    output logic                            busGrant,
    output logic                            avmWaitrequest,
    output logic [15:0]                     avmReaddata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] waited;
    logic       toggle;
    // stall each access for waitCycles edges, so slow memory is exercised too
    assign avmWaitrequest = waited != waitCycles;
    // outside a read the lines keep moving, never a stale word
    assign avmReaddata = avmReq.read ? avmReq.address[15:0] ^ 16'h5A5A : {16{toggle}};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            waited <= '0;
            toggle <= 1'h0;
            busGrant <= 1'h0;
        end else begin
            toggle <= !toggle;
            busGrant <= busRequest;
            if (!(avmReq.read || avmReq.write) || !avmWaitrequest) begin
                waited <= '0;
            end else begin
                waited <= waited + 2'h1;
            end
        end
    end
endmodule

// *** test/fadc_channel_checker.sv ***
module fadc_channel_checker (
    input wire logic                       clk,
    input wire logic                       reset_n,
    input wire fadc_pkg::fadc_avs_req_type avsReq,
    input wire logic                       avsWaitrequest,
    input wire fadc_pkg::fadc_avm_req_type avmReq,
    input wire logic                       avmWaitrequest,
    input wire logic                       busRequest,
    input wire logic                       busGrant,
    input wire logic                       priorityRequest,
    input wire fadc_pkg::fadc_events_type  events,
    input wire logic                       transferEndIrq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic acc;
    logic accDone;
    assign acc = avmReq.write && !avmWaitrequest;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            accDone <= 1'h0;
        end else begin
            accDone <= acc;
        end
    end
    slave_one_wait_a : assert property (
        (avsReq.read || avsReq.write) && avsWaitrequest |=> !avsWaitrequest ##1 avsWaitrequest)
        else $error("slave answer not one wait cycle");
    strobe_exclusive_a : assert property (!(avmReq.read && avmReq.write))
        else $error("read and write strobes together");
    read_hold_a : assert property (
        avmReq.read && avmWaitrequest |=> avmReq.read && $stable(avmReq.address))
        else $error("read dropped or address moved while stalled");
    write_hold_a : assert property (
        avmReq.write && avmWaitrequest |=> avmReq.write && $stable(avmReq.address)
        && $stable(avmReq.writedata))
        else $error("write dropped or changed while stalled");
    read_then_write_a : assert property (avmReq.read && !avmWaitrequest |=> avmReq.write)
        else $error("accepted read not followed by write");
    one_write_a : assert property (acc |=> !avmReq.write)
        else $error("write repeated after acceptance");
    bus_owned_a : assert property (
        avmReq.read || avmReq.write |-> busRequest && busGrant)
        else $error("strobe without bus ownership");
    byte_lane_a : assert property (
        avmReq.write && avmReq.byteenable != 2'b11 |-> avmReq.writedata[15:8] ==
        avmReq.writedata[7:0] && avmReq.byteenable == (avmReq.address[0] ? 2'b10 : 2'b01))
        else $error("byte write lane wrong");
    prio_release_a : assert property (priorityRequest && acc |=> !avmReq.read)
        else $error("bus kept against higher priority");
    irq_after_end_a : assert property (
        $rose(transferEndIrq) |-> accDone || $past(accDone))
        else $error("end irq without final write");
    nmi_blocks_a : assert property (
        events.nmiClear && !busRequest |=> ##1 !busRequest [*3])
        else $error("start after master enable cleared");
    cover property ($rose(transferEndIrq));
    cover property (priorityRequest && acc);
    cover property (avmReq.write && avmReq.byteenable != 2'b11);
endmodule

bind fadc_channel fadc_channel_checker u_fadc_channel_checker (
    .clk, .reset_n, .avsReq, .avsWaitrequest, .avmReq, .avmWaitrequest, .busRequest,
    .busGrant, .priorityRequest, .events, .transferEndIrq
);

// *** test/fadc_channel_tb.sv ***
`include "fadc_defs.svh"

module fadc_channel_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       clk;
    logic                       reset_n;
    fadc_pkg::fadc_avs_req_type avsReq;
    logic                       avsWaitrequest;
    logic [31:0]                avsReaddata;
    fadc_pkg::fadc_avm_req_type avmReq;
    logic                       avmWaitrequest;
    logic [15:0]                avmReaddata;
    logic                       busRequest;
    logic                       busGrant;
    logic                       priorityRequest;
    fadc_pkg::fadc_events_type  events;
    logic                       transferEndIrq;
    logic [1:0]                 waitCycles;
    logic [39:0]                wq[$];
    int                         n_errors;
    int                         compares;
    int                         cycles;
    logic [31:0]                q;

    fadc_channel u_fadc_channel (.clk, .reset_n, .avsReq, .avsWaitrequest, .avsReaddata,
        .avmReq, .avmWaitrequest, .avmReaddata, .busRequest, .busGrant, .priorityRequest,
        .events, .transferEndIrq);
    fadc_mem_model u_fadc_mem_model (.clk, .reset_n, .avmReq, .busRequest, .waitCycles,
        .busGrant, .avmWaitrequest, .avmReaddata);

    function automatic logic [15:0] f(input logic [23:0] a);
        return a[15:0] ^ 16'h5A5A;
    endfunction

    task automatic wrap_up();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic avs(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        avsReq.address <= a;
        avsReq.write <= wr;
        avsReq.read <= !wr;
        avsReq.writedata <= d;
        avsReq.byteenable <= 4'hF;
        do begin
            @(posedge clk);
        end while (avsWaitrequest !== 1'b0);
        q = avsReaddata;
        avsReq.read <= 1'h0;
        avsReq.write <= 1'h0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        avs(1'h0, a, '0, q);
        chk({8'h00, q}, {8'h00, exp});
    endtask

    // loads first, enables last, master before channel; end irq enable is written with ca, not masked
    task automatic setup(input logic [23:0] s, input logic [23:0] d, input logic [15:0] x,
                         input logic [15:0] b, input logic [7:0] cb, input logic [7:0] ca,
                         input logic nmi);
        logic [31:0] q;
        avs(1'h1, `FADC_OFS_SRC_ADDR, {8'h00, s}, q);
        avs(1'h1, `FADC_OFS_DST_ADDR, {8'h00, d}, q);
        avs(1'h1, `FADC_OFS_XFER_COUNT, {16'h0000, x}, q);
        avs(1'h1, `FADC_OFS_BLOCK_COUNT, {16'h0000, b}, q);
        avs(1'h1, `FADC_OFS_CONTROL_B, {24'h0, cb}, q);
        avs(1'h1, `FADC_OFS_CONTROL_A, {24'h0, ca}, q);
        avs(1'h0, `FADC_OFS_CONTROL_B, '0, q);
        avs(1'h1, `FADC_OFS_CONTROL_B, q | 32'h1, q);
        if (nmi) begin
            events.nmiClear <= 1'h1;
            @(posedge clk);
            events.nmiClear <= 1'h0;
        end
        avs(1'h0, `FADC_OFS_CONTROL_A, '0, q);
        avs(1'h1, `FADC_OFS_CONTROL_A, q | 32'h1, q);
    endtask

    task automatic wait_writes(input int n);
        while (wq.size() < n) @(posedge clk);
        repeat (20) @(posedge clk);
    endtask

    initial begin
        clk = 1'h0;
        forever #2 clk = !clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (avmReq.write && avmWaitrequest === 1'b0) wq.push_back({avmReq.address, avmReq.writedata});
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        reset_n = 1'h0;
        avsReq = '0;
        events = '0;
        events.dreqN = 1'h1;
        priorityRequest = 1'h0;
        waitCycles = 2'h0;
        repeat (8) @(posedge clk);
        reset_n <= 1'h1;
        // normal auto burst, word, source up, destination down, yielding to priority
        priorityRequest <= 1'h1;
        setup(24'h001000, 24'h002000, 16'h0003, 16'h0000, 8'h26, 8'hCE, 1'h0);
        wait_writes(3);
        priorityRequest <= 1'h0;
        for (int i = 0; i < 3; i++) begin
            chk(wq[i], {24'h002000 - 24'(2 * i), f(24'h001000 + 24'(2 * i))});
        end
        rd(`FADC_OFS_SRC_ADDR, 32'h0000_1006);
        rd(`FADC_OFS_DST_ADDR, 32'h0000_1FFA);
        rd(`FADC_OFS_XFER_COUNT, 32'h0000_0000);
        rd(`FADC_OFS_CONTROL_A, 32'h0000_00CE);
        chk({39'h0, transferEndIrq}, 40'h1);
        rd(5'h1C, 32'h0000_0000);
        // normal external edge, byte, source fixed, slow memory, no end irq
        wq.delete();
        waitCycles <= 2'h2;
        setup(24'h003001, 24'h004000, 16'h0002, 16'h0000, 8'h32, 8'hC0, 1'h0);
        for (int i = 1; i < 3; i++) begin
            events.dreqN <= 1'h0;
            repeat (2) @(posedge clk);
            events.dreqN <= 1'h1;
            wait_writes(i);
            chk(40'(wq.size()), 40'(i));
            chk(wq[i - 1], {24'h004000 + 24'(i - 1), 16'h6A6A});
        end
        chk({39'h0, transferEndIrq}, 40'h0);
        rd(`FADC_OFS_CONTROL_A, 32'h0000_00C0);
        // block mode, timer 1, two blocks of two words, source is the block area
        wq.delete();
        waitCycles <= 2'h0;
        setup(24'h005000, 24'h006000, 16'h0202, 16'h0002, 8'h4A, 8'hEE, 1'h0);
        for (int i = 1; i < 3; i++) begin
            events.timerMatch <= 4'h1;
            @(posedge clk);
            events.timerMatch <= 4'h2;
            @(posedge clk);
            events.timerMatch <= 4'h0;
            wait_writes(2 * i);
            chk(40'(wq.size()), 40'(2 * i));
            chk(wq[2 * i - 1], {24'h006002 + 24'(4 * i - 4), f(24'h005002)});
            rd(`FADC_OFS_SRC_ADDR, 32'h0000_5000);
            rd(`FADC_OFS_XFER_COUNT, 32'h0000_0202);
            rd(`FADC_OFS_BLOCK_COUNT, 32'(2 - i));
            chk({39'h0, transferEndIrq}, 40'(i - 1));
        end
        rd(`FADC_OFS_CONTROL_A, 32'h0000_00EE);
        // master enable lost to nmi during setup
        wq.delete();
        setup(24'h007000, 24'h008000, 16'h0000, 16'h0000, 8'h28, 8'hC0, 1'h1);
        repeat (30) @(posedge clk);
        chk(40'(wq.size()), 40'h0);
        rd(`FADC_OFS_CONTROL_B, 32'h0000_0028);
        // zero count: one edge request, count wraps and the channel stays enabled
        avs(1'h1, `FADC_OFS_CONTROL_B, 32'h0000_0031, q);
        events.dreqN <= 1'h0;
        repeat (2) @(posedge clk);
        events.dreqN <= 1'h1;
        wait_writes(1);
        chk(40'(wq.size()), 40'h1);
        rd(`FADC_OFS_XFER_COUNT, 32'h0000_FFFF);
        rd(`FADC_OFS_CONTROL_A, 32'h0000_00C1);
        wrap_up();
    end
endmodule
